// *** core/eprom_addr_counter.sv ***
// Address counter of the EPROM, clocked by the programmer's address clock.
`timescale 1ns/1ns
module eprom_addr_counter
  import eprom_prog_pkg::*;
(
  input  wire logic              addr_clk_i,
  input  wire logic              addr_rst_i,
  input  wire logic              hv_i,
  output logic [ADDR_W-1:0]      gray_o
);

  typedef struct packed {
    logic              hv_s1;
    logic              hv_s2;
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] gray;
  } cnt_state_t;

  cnt_state_t s;
  cnt_state_t next_s;

  // The counter is cleared while no high voltage is seen, so the link needs no reset of
  // its own, as long as the address clock ticks outside a session; a stopped clock keeps the old count.
  always_comb begin
    next_s       = s;
    next_s.hv_s1 = hv_i;
    next_s.hv_s2 = s.hv_s1;
    if (!s.hv_s2 || addr_rst_i) begin
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + 12'h001;
    end
    next_s.gray = next_s.cnt ^ (next_s.cnt >> 1);
  end

  // Gray code lets the system domain sample the address one bit change at a time.
  always_ff @(posedge addr_clk_i) begin
    s <= next_s;
  end

  assign gray_o = s.gray;

  AST_ADDR_CLEAR: assert property (@(posedge addr_clk_i) disable iff (!s.hv_s2)
    addr_rst_i |=> s.cnt == 12'h000)
    else $error("Address counter not cleared by address reset.");

  AST_ADDR_STEP: assert property (@(posedge addr_clk_i) disable iff (!s.hv_s2)
    !addr_rst_i && s.hv_s1 |=> s.cnt == $past(s.cnt) + 12'h001)
    else $error("Address counter did not advance by one.");

endmodule

// *** core/eprom_prog_pkg.sv ***
// Constants shared by the EPROM programming port and its address counter.
package eprom_prog_pkg;

  // Array geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_PORT_OUT = 8'h00;
  localparam logic [7:0] OFS_PORT_DIR = 8'h04;
  localparam logic [7:0] OFS_PORT_IN  = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;

  // Reset values of the writable registers.
  localparam logic [11:0] PORT_OUT_RST = 12'h000;
  localparam logic [7:0]  PORT_DIR_RST = 8'h00;

  // Field positions inside the synchroniser vector.
  localparam int IDX_P2   = 0;
  localparam int IDX_P3LO = 8;
  localparam int IDX_P3HI = 12;
  localparam int IDX_PVP  = 16;
  localparam int SYNC_W   = 17;

  // Control meanings of port bits while high voltage is seen.
  localparam int P2_CHIP_EN_N   = 0;
  localparam int P2_PROG_STROBE = 1;
  localparam int P3_CLAMP_DIS   = 0;
  localparam int P3_OPT_READ    = 1;
  localparam int P3_OUT_EN      = 2;
  localparam int P3_MODE_LATCH  = 3;

  // Status register field positions.
  localparam int ST_HV   = 0;
  localparam int ST_OPT  = 1;
  localparam int ST_MODE = 8;
  localparam int ST_ADDR = 16;

  // Mode that routes programming to the option bits.
  localparam logic [7:0]  MODE_OPTION     = 8'h03;
  localparam logic [11:0] ADDR_MODE_LATCH = 12'h003;

endpackage

// *** core/eprom_program_port.sv ***
// EPROM programming port: pin rerouting, mode latch, data bus and register access.
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
module eprom_program_port
  import eprom_prog_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              prog_voltage_pin_i,
  input  wire logic              addr_clk_i,
  input  wire logic              addr_rst_i,
  input  wire logic [7:0]        p2_i,
  output logic [7:0]             p2_o,
  output logic [7:0]             p2_oe_n_o,
  input  wire logic [3:0]        p3_lo_i,
  input  wire logic [3:0]        p3_hi_i,
  output logic [3:0]             p3_hi_o,
  output logic [3:0]             p3_hi_oe_n_o,
  input  wire logic [DATA_W-1:0] ep_rdata_i,
  input  wire logic              ep_protect_i,
  output logic                   ep_chip_en_n_o,
  output logic                   ep_prog_strobe_n_o,
  output logic                   ep_precharge_o,
  output logic                   ep_clamp_dis_o,
  output logic                   ep_option_sel_o,
  output logic                   ep_read_allow_o,
  output logic [ADDR_W-1:0]      ep_addr_o,
  output logic [DATA_W-1:0]      ep_wdata_o,
  output logic [7:0]             mode_o
);

  typedef struct packed {
    logic [SYNC_W-1:0] sy1;
    logic [SYNC_W-1:0] sy2;
    logic [ADDR_W-1:0] gy1;
    logic [ADDR_W-1:0] gy2;
    logic              hv;
    logic              ml_prev;
    logic [7:0]        mode;
    logic              opt_rd;
    logic              opt_taken;
    logic [11:0]       port_out;
    logic [7:0]        port_dir;
    logic              ack;
    logic [31:0]       rdata;
    logic [7:0]        p2_out;
    logic [7:0]        p2_oen;
    logic [3:0]        p3_out;
    logic [3:0]        p3_oen;
    logic              ce_n;
    logic              pgm_n;
    logic              prech;
    logic              clamp;
    logic              opt_sel;
    logic              rd_allow;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;

  logic [ADDR_W-1:0] link_gray;

  // Gathers the eight data bits from the pins that carry them.
  function automatic logic [7:0] pins_to_data(input logic [7:0] p2, input logic [3:0] p3h);
    logic [7:0] d;
    d = 8'h00;
    for (int k = 0; k < 4; k++) begin
      d[k]     = p3h[k];
      d[4 + k] = p2[7 - k];
    end
    return d;
  endfunction

  // Places data bits 4 to 7 onto port 2 bits 7 down to 4.
  function automatic logic [3:0] data_to_p2hi(input logic [7:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int k = 0; k < 4; k++) begin
      p[3 - k] = d[4 + k];
    end
    return p;
  endfunction

  // Turns the synchronised gray count back into a binary address.
  function automatic logic [ADDR_W-1:0] gray_to_bin(input logic [ADDR_W-1:0] g);
    logic [ADDR_W-1:0] b;
    b = '0;
    b[ADDR_W-1] = g[ADDR_W-1];
    for (int k = ADDR_W - 2; k >= 0; k--) begin
      b[k] = b[k + 1] ^ g[k];
    end
    return b;
  endfunction

  // The counter lives on the programmer's address clock.
  eprom_addr_counter u_counter (
    .addr_clk_i (addr_clk_i),
    .addr_rst_i (addr_rst_i),
    .hv_i       (s.hv),
    .gray_o     (link_gray)
  );

  // Synchronised views of the pins; only second-stage flops are read below.
  logic [7:0] p2_pins;
  logic [3:0] p3l_pins;
  logic [3:0] p3h_pins;
  logic       hv;
  logic       oe_pin;
  logic       ml_pin;
  logic [7:0] bus_data;

  assign p2_pins  = s.sy2[IDX_P2 +: 8];
  assign p3l_pins = s.sy2[IDX_P3LO +: 4];
  assign p3h_pins = s.sy2[IDX_P3HI +: 4];
  assign hv       = s.sy2[IDX_PVP];
  assign oe_pin   = p3l_pins[P3_OUT_EN];
  assign ml_pin   = p3l_pins[P3_MODE_LATCH];
  assign bus_data = pins_to_data(p2_pins, p3h_pins);

  logic        wb_req;
  logic [31:0] rd_word;

  assign wb_req = wb_cyc_i && wb_stb_i && !s.ack;

  // Read mux; unmapped offsets read as zero so a stray read still completes.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      OFS_PORT_OUT: rd_word[11:0] = s.port_out;
      OFS_PORT_DIR: rd_word[7:0]  = s.port_dir;
      OFS_PORT_IN:  rd_word[15:0] = {p3h_pins, p3l_pins, p2_pins};
      OFS_STATUS: begin
        rd_word[ST_HV]               = s.hv;
        rd_word[ST_OPT]              = s.opt_rd;
        rd_word[ST_MODE +: 8]        = s.mode;
        rd_word[ST_ADDR +: ADDR_W]   = s.addr;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Next-state logic for the whole port.
  always_comb begin
    next_s     = s;
    next_s.sy1 = {prog_voltage_pin_i, p3_hi_i, p3_lo_i, p2_i};
    next_s.sy2 = s.sy1;
    next_s.gy1 = link_gray;
    next_s.gy2 = s.gy1;
    next_s.hv  = hv;

    // Bus slave: one ack per request, dropped in the following cycle.
    next_s.ack = wb_req;
    if (wb_req) begin
      next_s.rdata = rd_word;
    end
    if (wb_req && wb_we_i) begin
      if (wb_adr_i == OFS_PORT_OUT) begin
        if (wb_sel_i[0]) begin
          next_s.port_out[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          next_s.port_out[11:8] = wb_dat_i[11:8];
        end
      end
      if (wb_adr_i == OFS_PORT_DIR && wb_sel_i[0]) begin
        next_s.port_dir = wb_dat_i[7:0];
      end
    end

    // Mode latch acts on the rising pin level and only under high voltage.
    next_s.ml_prev = ml_pin;
    if (hv && ml_pin && !s.ml_prev) begin
      next_s.mode = bus_data;
    end

    // The option-read strap is taken once, in the first cycle after reset.
    if (!s.opt_taken) begin
      next_s.opt_taken = 1'b1;
      next_s.opt_rd    = p3l_pins[P3_OPT_READ];
    end

    if (hv) begin
      // Programming session: pins carry EPROM control and data.
      next_s.ce_n     = p2_pins[P2_CHIP_EN_N];
      next_s.pgm_n    = p2_pins[P2_PROG_STROBE];
      next_s.prech    = oe_pin;
      next_s.clamp    = p3l_pins[P3_CLAMP_DIS];
      next_s.opt_sel  = (s.mode == MODE_OPTION);
      next_s.rd_allow = !ep_protect_i || s.opt_rd;
      next_s.addr     = gray_to_bin(s.gy2);
      next_s.wdata    = bus_data;
      next_s.p2_out   = {data_to_p2hi(ep_rdata_i), 4'h0};
      next_s.p2_oen   = {{4{oe_pin}}, 4'hF};
      next_s.p3_out   = ep_rdata_i[3:0];
      next_s.p3_oen   = {4{oe_pin}};
    end else begin
      // Normal port use; the EPROM sees idle, deselected controls.
      next_s.ce_n     = 1'b1;
      next_s.pgm_n    = 1'b1;
      next_s.prech    = 1'b1;
      next_s.clamp    = 1'b0;
      next_s.opt_sel  = 1'b0;
      next_s.rd_allow = 1'b0;
      next_s.addr     = '0;
      next_s.wdata    = 8'h00;
      next_s.p2_out   = s.port_out[7:0];
      next_s.p2_oen   = ~s.port_dir;
      next_s.p3_out   = s.port_out[11:8];
      next_s.p3_oen   = 4'h0;
    end

    // Reset keeps the pin synchronisers moving so the strap is valid at release; the gray synchroniser is cleared.
    if (!rst_n_i) begin
      next_s.gy1       = '0;
      next_s.gy2       = '0;
      next_s.hv        = 1'b0;
      next_s.ml_prev   = 1'b1;
      next_s.mode      = 8'h00;
      next_s.opt_rd    = 1'b0;
      next_s.opt_taken = 1'b0;
      next_s.port_out  = PORT_OUT_RST;
      next_s.port_dir  = PORT_DIR_RST;
      next_s.ack       = 1'b0;
      next_s.rdata     = 32'h0000_0000;
      next_s.p2_out    = 8'h00;
      next_s.p2_oen    = 8'hFF;
      next_s.p3_out    = 4'h0;
      next_s.p3_oen    = 4'hF;
      next_s.ce_n      = 1'b1;
      next_s.pgm_n     = 1'b1;
      next_s.prech     = 1'b1;
      next_s.clamp     = 1'b0;
      next_s.opt_sel   = 1'b0;
      next_s.rd_allow  = 1'b0;
      next_s.addr      = '0;
      next_s.wdata     = 8'h00;
    end
  end

  // Single register stage for all state.
  always_ff @(posedge clock_i) begin
    s <= next_s;
  end

  // Every output comes straight from a flop.
  assign wb_dat_o           = s.rdata;
  assign wb_ack_o           = s.ack;
  assign p2_o               = s.p2_out;
  assign p2_oe_n_o          = s.p2_oen;
  assign p3_hi_o            = s.p3_out;
  assign p3_hi_oe_n_o       = s.p3_oen;
  assign ep_chip_en_n_o     = s.ce_n;
  assign ep_prog_strobe_n_o = s.pgm_n;
  assign ep_precharge_o     = s.prech;
  assign ep_clamp_dis_o     = s.clamp;
  assign ep_option_sel_o    = s.opt_sel;
  assign ep_read_allow_o    = s.rd_allow;
  assign ep_addr_o          = s.addr;
  assign ep_wdata_o         = s.wdata;
  assign mode_o             = s.mode;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  AST_CE_GATED: assert property (!hv |=> ep_chip_en_n_o && ep_prog_strobe_n_o)
    else $error("EPROM controls active without high voltage.");

  AST_STROBE_FOLLOWS: assert property (hv |=> ep_prog_strobe_n_o == $past(p2_pins[1]))
    else $error("Program strobe does not follow its pin.");

  AST_PRECHARGE: assert property (hv |=> ep_precharge_o == $past(oe_pin))
    else $error("Precharge does not follow output enable.");

  AST_BUS_DIR: assert property (hv && !oe_pin |=> p2_oe_n_o == 8'h0F && p3_hi_oe_n_o == 4'h0)
    else $error("Data pins not driven while output enable is low.");

  AST_MODE_LATCH: assert property (hv && ml_pin && !s.ml_prev |=> mode_o == $past(bus_data))
    else $error("Mode register missed the latch pulse.");

  AST_MODE_HOLD: assert property (!hv |=> $stable(mode_o))
    else $error("Mode changed without high voltage.");

  AST_CLAMP: assert property (hv |=> ep_clamp_dis_o == $past(p3l_pins[0]))
    else $error("Clamp disable does not follow its pin.");

  AST_DATA_MAP: assert property (hv |=> ep_wdata_o[4] == $past(p2_pins[7])
    && ep_wdata_o[0] == $past(p3h_pins[0]))
    else $error("Data bit mapping wrong.");

  AST_NORMAL_PORT: assert property (!hv |=> p2_o == $past(s.port_out[7:0]))
    else $error("Port 2 not in normal function without high voltage.");

  AST_OPT_READ: assert property (hv && s.opt_rd |=> ep_read_allow_o)
    else $error("Option read blocked despite the strap.");

  AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Bus ack held for more than one cycle.");

  AST_CE_FOLLOWS: assert property (hv |=>
    ep_chip_en_n_o == $past(p2_pins[P2_CHIP_EN_N]))
    else $error("Chip enable does not follow its pin.");

  AST_OPT_SEL: assert property (hv |=>
    ep_option_sel_o == ($past(mode_o) == MODE_OPTION))
    else $error("Option select does not follow the latched mode.");

  AST_BUS_IN: assert property (hv && oe_pin |=>
    p2_oe_n_o == 8'hFF && p3_hi_oe_n_o == 4'hF)
    else $error("Data pins driven while output enable is high.");

  AST_READ_OUT: assert property (hv |=>
    p3_hi_o == $past(ep_rdata_i[3:0]))
    else $error("Low read data bits not placed on port 3.");

  AST_IDLE_EPROM: assert property (!hv |=>
    ep_addr_o == 12'h000 && ep_wdata_o == 8'h00)
    else $error("EPROM address or data active without high voltage.");

  AST_NORMAL_DIR: assert property (!hv |=>
    p2_oe_n_o == ~$past(s.port_dir))
    else $error("Port 2 direction not from its register without high voltage.");

endmodule

// *** sim/eprom_program_port_tb_top.sv ***
// Self-checking bench: bus reads and pin snapshots are noted in queues and checked by two watchers.
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module eprom_program_port_tb_top;
  import eprom_prog_pkg::*;
  logic        clock_i, rst_n_i = 1'b0, cyc = 1'b0, we = 1'b0, ack, pvp, aclk, arst;
  logic        protect = 1'b1, e_hv = 1'b0;
  logic [7:0]  adr = 8'h00, p2, p2_o, p2_oe_n, rd_byte = 8'h00, wd, mode;
  logic [3:0]  sel = 4'h0, p3_lo, p3_hi, p3_hi_o, p3_hi_oe_n, e_lo = 4'b0110;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [11:0] addr, e_addr = 12'h000, e_port = 12'h000;
  logic [7:0]  e_data = 8'hff, e_mode = 8'h00;
  logic [1:0]  e_ctl = 2'b11;
  logic [5:0]  ctl_out;
  logic [32:0] bq[$], bn;
  logic [49:0] pe[$], pm[$], pn, pk, obs;
  int          n_mismatch = 0, total_checks = 0;
  event        snap;

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  eprom_program_port uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .prog_voltage_pin_i(pvp), .addr_clk_i(aclk),
    .addr_rst_i(arst), .p2_i(p2), .p2_o(p2_o), .p2_oe_n_o(p2_oe_n), .p3_lo_i(p3_lo),
    .p3_hi_i(p3_hi), .p3_hi_o(p3_hi_o), .p3_hi_oe_n_o(p3_hi_oe_n), .ep_rdata_i(rd_byte),
    .ep_protect_i(protect), .ep_chip_en_n_o(ctl_out[5]), .ep_prog_strobe_n_o(ctl_out[4]),
    .ep_precharge_o(ctl_out[3]), .ep_clamp_dis_o(ctl_out[2]), .ep_option_sel_o(ctl_out[1]),
    .ep_read_allow_o(ctl_out[0]), .ep_addr_o(addr), .ep_wdata_o(wd), .mode_o(mode));
  eprom_programmer_model prog (.clock_i(clock_i), .p2_drv_i(p2_o), .p2_oe_n_i(p2_oe_n),
    .p3_drv_i(p3_hi_o), .p3_oe_n_i(p3_hi_oe_n), .pvp_o(pvp), .aclk_o(aclk), .arst_o(arst),
    .p2_o(p2), .p3_lo_o(p3_lo), .p3_hi_o(p3_hi));

  assign obs = {p3_hi_oe_n, p3_hi_o, p2_oe_n[7:4], p2_o[7:4], ctl_out, addr, wd, mode};

  // Each acknowledge consumes the oldest bus note; writes carry no comparison.
  always @(posedge clock_i) begin
    if (ack === 1'b1 && bq.size() > 0) begin
      bn = bq.pop_front();
      if (bn[32])
        `CHECK(rdat, bn[31:0])
    end
  end

  // Each snapshot request consumes the oldest pin note, compared under its mask.
  always begin
    @(snap);
    pn = pe.pop_front();
    pk = pm.pop_front();
    `CHECK(obs & pk, pn & pk)
  end

  // One classic cycle; the request is held until ack is sampled high or 50 cycles pass.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [31:0] e);
    int n;
    n = 0;
    bq.push_back({~w, e});
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      n_mismatch++;
    cyc <= 1'b0;
    @(posedge clock_i);
  endtask

  // Pin outputs settle within a few cycles; write data is skipped while the port drives the bus.
  task automatic chk();
    logic r;
    repeat (8) @(posedge clock_i);
    #1;
    r = e_hv && !e_lo[2];
    if (!e_hv)
      pe.push_back({4'h0, e_port[11:8], 4'hf, e_port[7:4], 6'b111000, 12'h000, 8'h00,
                    e_mode});
    else
      pe.push_back({{4{e_lo[2]}}, rd_byte[3:0], {4{e_lo[2]}}, rd_byte[4], rd_byte[5],
                    rd_byte[6], rd_byte[7], e_ctl[0], e_ctl[1], e_lo[2], e_lo[0],
                    e_mode == MODE_OPTION, 1'b1, e_addr, e_data, e_mode});
    pm.push_back(r ? {34'h3_ffff_ffff, 8'h00, 8'hff} : {50{1'b1}});
    -> snap;
  endtask

  task automatic pins(input logic [1:0] c, input logic [3:0] lo, input logic [7:0] d,
                      input logic en);
    prog.set_pins(c, lo, d, en);
    e_ctl = c;
    e_lo = lo;
    e_data = en ? d : 8'hff;
    chk();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence: registers, pin control in a session, counter, option programming, exit.
  initial begin
    int          n;
    logic [31:0] v;
    void'($urandom(32'h0000_b539));
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    v = $urandom;
    xfer(1'b0, OFS_PORT_OUT, 32'h0, 4'hf, {20'h0, PORT_OUT_RST});
    xfer(1'b0, OFS_PORT_DIR, 32'h0, 4'hf, {24'h0, PORT_DIR_RST});
    xfer(1'b1, OFS_PORT_OUT, v, 4'h3, 32'h0);
    xfer(1'b0, OFS_PORT_OUT, 32'h0, 4'hf, {20'h0, v[11:0]});
    xfer(1'b1, OFS_PORT_OUT, ~v, 4'h1, 32'h0);
    xfer(1'b0, OFS_PORT_OUT, 32'h0, 4'hf, {20'h0, v[11:8], ~v[7:0]});
    xfer(1'b1, 8'h10, v, 4'hf, 32'h0);
    xfer(1'b0, 8'h10, 32'h0, 4'hf, 32'h0);
    xfer(1'b1, OFS_STATUS, 32'hffff_ffff, 4'hf, 32'h0);
    xfer(1'b0, OFS_STATUS, 32'h0, 4'hf, 32'h0000_0002);
    e_port = {v[11:8], ~v[7:0]};
    xfer(1'b0, OFS_PORT_IN, 32'h0, 4'hf, {16'h0, e_port[11:8], 4'h6, 8'hf3});
    pins(2'b00, 4'b0111, 8'h5a, 1'b1);
    $display("test registers done");
    prog.set_hv(1'b1);
    e_hv = 1'b1;
    prog.addr_burst(1'b1, 3);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i);
      rd_byte <= 8'($urandom);
      pins(2'($urandom), {1'b0, 1'(i < 6), 1'b1, 1'($urandom)}, 8'($urandom), 1'(i < 6));
    end
    $display("test pin control done");
    for (int i = 0; i < 3; i++) begin
      n = 1 + $urandom % 20;
      prog.addr_burst(1'b0, n);
      e_addr += 12'(n);
      chk();
    end
    $display("test counter done");
    prog.addr_burst(1'b1, 1);
    e_addr = 12'h000;
    prog.addr_burst(1'b0, 3);
    e_addr = ADDR_MODE_LATCH;
    pins(2'b11, 4'b0110, MODE_OPTION, 1'b1);
    prog.set_pins(2'b11, 4'b1110, MODE_OPTION, 1'b1);
    e_mode = MODE_OPTION;
    pins(2'b11, 4'b0110, MODE_OPTION, 1'b1);
    prog.addr_burst(1'b1, 1);
    e_addr = 12'h000;
    pins(2'b00, 4'b0110, 8'($urandom), 1'b1);
    xfer(1'b0, OFS_STATUS, 32'h0, 4'hf, {4'h0, e_addr, e_mode, 8'h03});
    $display("test option programming done");
    prog.set_hv(1'b0);
    e_hv = 1'b0;
    e_addr = 12'h000;
    pins(2'b11, 4'b0110, 8'h81, 1'b1);
    prog.set_pins(2'b11, 4'b1110, 8'h81, 1'b1);
    pins(2'b11, 4'b0110, 8'h81, 1'b1);
    $display("test session exit done");
    report_and_stop();
  end

  // Watchdog sized well beyond the few thousand nanoseconds the sequence needs.
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule

// *** sim/eprom_programmer_model.sv ***
// Pin-level model of the external programmer, with pull-ups on released lines.
`timescale 1ns/1ns
module eprom_programmer_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] p2_drv_i,
  input  wire logic [7:0] p2_oe_n_i,
  input  wire logic [3:0] p3_drv_i,
  input  wire logic [3:0] p3_oe_n_i,
  output logic            pvp_o,
  output logic            aclk_o,
  output logic            arst_o,
  output logic [7:0]      p2_o,
  output logic [3:0]      p3_lo_o,
  output logic [3:0]      p3_hi_o
);
  logic [1:0] ctl;
  logic [7:0] data;
  logic       den;
  logic [7:0] p2_prog;

  // The option-read strap is held high from power-up so that the first cycle after reset captures it.
  initial begin
    {pvp_o, aclk_o, arst_o, den} = 4'h0;
    ctl = 2'b11;
    data = 8'h00;
    p3_lo_o = 4'b0110;
  end

  // A line that neither side drives rests at its pull-up level, never at a stale value.
  assign p2_prog = {data[4], data[5], data[6], data[7], arst_o, aclk_o, ctl};
  always_comb begin
    for (int i = 0; i < 8; i++)
      p2_o[i] = !p2_oe_n_i[i] ? p2_drv_i[i] : ((i < 4 || den) ? p2_prog[i] : 1'b1);
    for (int i = 0; i < 4; i++)
      p3_hi_o[i] = !p3_oe_n_i[i] ? p3_drv_i[i] : (den ? data[i] : 1'b1);
  end

  task automatic set_hv(input logic v);
    @(posedge clock_i);
    pvp_o <= v;
  endtask

  task automatic set_pins(input logic [1:0] c, input logic [3:0] lo, input logic [7:0] d,
                          input logic en);
    @(posedge clock_i);
    ctl <= c;
    p3_lo_o <= lo;
    data <= d;
    den <= en;
  endtask

  // Address clock bursts at 30 ns; the line rests low between bursts.
  task automatic addr_burst(input logic rst, input int n);
    #7;
    arst_o = rst;
    repeat (n) begin
      #15 aclk_o = 1'b1;
      #15 aclk_o = 1'b0;
    end
    #7 arst_o = 1'b0;
  endtask
endmodule
